// *** modulator_model.sv ***
module modulator_model (
  // modulator pins
  output logic       mclk,
  output logic [3:0] bits
);
  timeunit 1ns;
  timeprecision 1ns;

  // free-running modulator clock from a known low level, 800 ns period
  initial begin
    mclk = 1'b0;
    forever #400 mclk = ~mclk;
  end

  // ch0 all ones, ch1 all zeros, ch2/ch3 toggle in opposite phase;
  // bits move on the falling edge so the rising sample sees them stable
  initial begin
    bits = 4'b0001;
    forever begin
      @(negedge mclk);
      bits <= {bits[2], ~bits[2], 2'b01};
    end
  end
endmodule : modulator_model

// *** sdf_channel.sv ***
module sdf_channel (
  // clock and reset
  input  logic                        clk,
  input  logic                        rst,
  // synchronised bitstream
  input  logic                        sample,
  input  logic                        bit_in,
  // data filter settings
  input  logic                        data_en,
  input  logic                        data_type,
  input  logic [sdf_pkg::OSR_W-1:0]   data_osr,
  input  logic                        data_restart,
  // comparator settings
  input  logic                        cmp_type,
  input  logic [sdf_pkg::OSR_W-1:0]   cmp_osr,
  input  logic                        cmp_restart,
  input  logic [sdf_pkg::ACC_W-1:0]   low_thr,
  input  logic [sdf_pkg::ACC_W-1:0]   high_thr,
  // results
  output logic                        ready,
  output logic [sdf_pkg::ACC_W-1:0]   data_value,
  output logic                        over,
  output logic                        under
);

  localparam int OW = sdf_pkg::OSR_W;
  localparam int AW = sdf_pkg::ACC_W;

  // selects the first or second integrator by filter shape
  function automatic logic [AW-1:0] pick(input logic t,
                                         input logic [AW-1:0] a1,
                                         input logic [AW-1:0] a2);
    pick = (t == sdf_pkg::SINC2) ? a2 : a1;
  endfunction : pick

  logic [OW-1:0] d_cnt_reg, d_cnt_next, c_cnt_reg, c_cnt_next;
  logic [AW-1:0] d1_reg, d1_next, d2_reg, d2_next;
  logic [AW-1:0] c1_reg, c1_next, c2_reg, c2_next;
  logic [AW-1:0] value_reg, value_next, inc, cval;
  logic          ready_reg, ready_next, over_reg, over_next;
  logic          under_reg, under_next, d_end, c_end;

  // integrate, dump at window end or on a settings change
  always_comb begin
    d_cnt_next = d_cnt_reg;
    d1_next    = d1_reg;
    d2_next    = d2_reg;
    c_cnt_next = c_cnt_reg;
    c1_next    = c1_reg;
    c2_next    = c2_reg;
    value_next = value_reg;
    ready_next = 1'b0;
    over_next  = 1'b0;
    under_next = 1'b0;
    inc   = {{(AW-1){1'b0}}, bit_in};
    d_end = data_restart || (sample && d_cnt_reg == data_osr - OW'(1));
    c_end = cmp_restart || (sample && c_cnt_reg == cmp_osr - OW'(1));
    if (!data_en) begin
      d_cnt_next = '0; // disabled filter restarts clean
      d1_next    = '0;
      d2_next    = '0;
    end else begin
      if (sample) begin
        d1_next    = d1_reg + inc;
        d2_next    = d2_reg + d1_reg + inc;
        d_cnt_next = d_cnt_reg + OW'(1);
      end
      if (d_end) begin
        ready_next = 1'b1; // partial window dumps on a change
        value_next = pick(data_type, d1_next, d2_next);
        d_cnt_next = '0;
        d1_next    = '0;
        d2_next    = '0;
      end
    end
    if (sample) begin
      c1_next    = c1_reg + inc;
      c2_next    = c2_reg + c1_reg + inc;
      c_cnt_next = c_cnt_reg + OW'(1);
    end
    cval = pick(cmp_type, c1_next, c2_next);
    if (c_end) begin
      over_next  = cval > high_thr; // change forces a compare
      under_next = cval < low_thr;
      c_cnt_next = '0;
      c1_next    = '0;
      c2_next    = '0;
    end
  end

  // register filter state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d_cnt_reg <= '0;
      d1_reg    <= '0;
      d2_reg    <= '0;
      c_cnt_reg <= '0;
      c1_reg    <= '0;
      c2_reg    <= '0;
      value_reg <= '0;
      ready_reg <= 1'b0;
      over_reg  <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      d_cnt_reg <= d_cnt_next;
      d1_reg    <= d1_next;
      d2_reg    <= d2_next;
      c_cnt_reg <= c_cnt_next;
      c1_reg    <= c1_next;
      c2_reg    <= c2_next;
      value_reg <= value_next;
      ready_reg <= ready_next;
      over_reg  <= over_next;
      under_reg <= under_next;
    end
  end

  assign ready      = ready_reg;
  assign data_value = value_reg;
  assign over       = over_reg;
  assign under      = under_reg;

  // settings change yields a data-ready one cycle later
  spur_ready_a: assert property (@(posedge clk) disable iff (rst)
    (data_en && data_restart) |=> ready_reg)
    else $error("no data-ready after data filter change");

  // settings change yields a compare against the new threshold
  spur_compare_a: assert property (@(posedge clk) disable iff (rst)
    cmp_restart |=> over_reg == ($past(cval) > $past(high_thr)))
    else $error("comparator change did not force a compare");

  // disabled filter stays silent
  data_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !data_en |=> !ready_reg)
    else $error("data-ready while filter disabled");

endmodule : sdf_channel

// *** sdf_pkg.sv ***
package sdf_pkg;

  // geometry
  localparam int CH_N  = 4;
  localparam int OSR_W = 8;
  localparam int ACC_W = 16;
  localparam int AW    = 8;
  localparam int DW    = 32;

  // register offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] DATA_OVERSAMPLING_RATIO_OFS  = 8'h04;
  localparam logic [7:0] COMPARATOR_OVERSAMPLING_RATIO_OFS  = 8'h08;
  localparam logic [7:0] LOW_OFS   = 8'h0c;
  localparam logic [7:0] HIGH_OFS  = 8'h10;
  localparam logic [7:0] FLAG_OFS  = 8'h14;
  localparam logic [7:0] MASK_OFS  = 8'h18;
  localparam logic [7:0] DATA_BASE = 8'h20;

  // control field positions
  localparam int CTRL_W      = 4;
  localparam int DATA_EN_BIT = 0;
  localparam int CMP_IE_BIT  = 1;
  localparam int DTYPE_BIT   = 2;
  localparam int CTYPE_BIT   = 3;

  // reset values
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [7:0]  DATA_OVERSAMPLING_RATIO_RST = 8'h20;
  localparam logic [7:0]  COMPARATOR_OVERSAMPLING_RATIO_RST = 8'h10;
  localparam logic [15:0] LOW_RST  = 16'h0010;
  localparam logic [15:0] HIGH_RST = 16'h00f0;

  // filter shapes
  typedef enum logic {
    SINC1 = 1'b0,
    SINC2 = 1'b1
  } filt_t;

endpackage : sdf_pkg

// *** sigma_delta_filter_module.sv ***
// Operation
// - comparator setting change raises comparator event
// - comparator events reach irq, task, crossbars
// - data setting change raises data-ready event
// - data-ready reaches irq, task and dma
// - over and under latched per channel
module sigma_delta_filter_module #(
  parameter int CH_N = sdf_pkg::CH_N
) (
  // clock and reset
  input  logic                       clk,
  input  logic                       rst,
  // modulator pins
  input  logic                       modulator_clock_input,
  input  logic [CH_N-1:0]            bitstream,
  // register port
  input  logic [sdf_pkg::AW-1:0]     addr,
  input  logic [sdf_pkg::DW-1:0]     wdata,
  input  logic                       wr,
  input  logic                       rd,
  output logic [sdf_pkg::DW-1:0]     rdata,
  // event consumers
  output logic                       irq,
  output logic                       math_coprocessor_task,
  output logic                       dma_trigger,
  output logic [CH_N-1:0]            crossbar_trip
);

  localparam int OW = sdf_pkg::OSR_W;
  localparam int AC = sdf_pkg::ACC_W;
  localparam int FW = 3 * CH_N;

  logic                    mclk_s1_reg, mclk_s2_reg, mclk_s3_reg, sample;
  logic [CH_N-1:0]         bit_s1_reg, bit_s2_reg;
  logic [CH_N-1:0]         ch_ready, ch_over, ch_under, cmp_ev, rdy_ev;
  logic [CH_N-1:0][AC-1:0] ch_value;
  logic [3:0]              ctrl_reg, ctrl_next;
  logic [OW-1:0]           data_oversampling_ratio_reg, data_oversampling_ratio_next, comparator_oversampling_ratio_reg, comparator_oversampling_ratio_next;
  logic [AC-1:0]           low_reg, low_next, high_reg, high_next;
  logic [FW-1:0]           flag_reg, flag_next, mask_reg, mask_next;
  logic [FW-1:0]           ev, w1c;
  logic [sdf_pkg::DW-1:0]  rdata_reg, rdata_next;
  logic                    cmp_rst_reg, cmp_rst_next, dat_rst_reg;
  logic                    dat_rst_next, irq_reg, irq_next;
  logic                    task_reg, task_next, dma_reg, dma_next;
  logic [CH_N-1:0]         trip_reg, trip_next;
  logic                    data_en, cmp_ie;

  // two-stage synchronisers, third stage only for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
      mclk_s3_reg <= 1'b0;
      bit_s1_reg  <= '0;
      bit_s2_reg  <= '0;
    end else begin
      mclk_s1_reg <= modulator_clock_input;
      mclk_s2_reg <= mclk_s1_reg;
      mclk_s3_reg <= mclk_s2_reg;
      bit_s1_reg  <= bitstream;
      bit_s2_reg  <= bit_s1_reg;
    end
  end

  assign sample  = mclk_s2_reg && !mclk_s3_reg;
  assign data_en = ctrl_reg[sdf_pkg::DATA_EN_BIT];
  assign cmp_ie  = ctrl_reg[sdf_pkg::CMP_IE_BIT];

  // one filter per channel, settings shared
  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    sdf_channel u_ch (
      .clk          (clk),
      .rst          (rst),
      .sample       (sample),
      .bit_in       (bit_s2_reg[i]),
      .data_en      (data_en),
      .data_type    (ctrl_reg[sdf_pkg::DTYPE_BIT]),
      .data_osr     (data_oversampling_ratio_reg),
      .data_restart (dat_rst_reg),
      .cmp_type     (ctrl_reg[sdf_pkg::CTYPE_BIT]),
      .cmp_osr      (comparator_oversampling_ratio_reg),
      .cmp_restart  (cmp_rst_reg),
      .low_thr      (low_reg),
      .high_thr     (high_reg),
      .ready        (ch_ready[i]),
      .data_value   (ch_value[i]),
      .over         (ch_over[i]),
      .under        (ch_under[i])
    );
  end

  // register writes, change detection, event routing, reads
  always_comb begin
    ctrl_next    = ctrl_reg;
    data_oversampling_ratio_next    = data_oversampling_ratio_reg;
    comparator_oversampling_ratio_next    = comparator_oversampling_ratio_reg;
    low_next     = low_reg;
    high_next    = high_reg;
    mask_next    = mask_reg;
    cmp_rst_next = 1'b0;
    dat_rst_next = 1'b0;
    rdata_next   = '0;
    if (wr) begin
      case (addr)
        sdf_pkg::CTRL_OFS: begin
          ctrl_next = wdata[sdf_pkg::CTRL_W-1:0];
          if (wdata[sdf_pkg::CTYPE_BIT] != ctrl_reg[sdf_pkg::CTYPE_BIT]) begin
            cmp_rst_next = 1'b1;
          end
          if (data_en && wdata[sdf_pkg::DATA_EN_BIT] &&
              wdata[sdf_pkg::DTYPE_BIT] != ctrl_reg[sdf_pkg::DTYPE_BIT]) begin
            dat_rst_next = 1'b1;
          end
        end
        sdf_pkg::DATA_OVERSAMPLING_RATIO_OFS: begin
          data_oversampling_ratio_next    = wdata[OW-1:0];
          dat_rst_next = data_en && (wdata[OW-1:0] != data_oversampling_ratio_reg);
        end
        sdf_pkg::COMPARATOR_OVERSAMPLING_RATIO_OFS: begin
          comparator_oversampling_ratio_next    = wdata[OW-1:0];
          cmp_rst_next = wdata[OW-1:0] != comparator_oversampling_ratio_reg;
        end
        sdf_pkg::LOW_OFS: begin
          low_next     = wdata[AC-1:0];
          cmp_rst_next = wdata[AC-1:0] != low_reg;
        end
        sdf_pkg::HIGH_OFS: begin
          high_next    = wdata[AC-1:0];
          cmp_rst_next = wdata[AC-1:0] != high_reg;
        end
        sdf_pkg::MASK_OFS: begin
          mask_next = wdata[FW-1:0];
        end
        default: begin
        end
      endcase
    end
    cmp_ev = (ch_over | ch_under) & {CH_N{cmp_ie}};
    rdy_ev = ch_ready & {CH_N{data_en}};
    ev  = {rdy_ev, ch_under & {CH_N{cmp_ie}}, ch_over & {CH_N{cmp_ie}}};
    w1c = (wr && addr == sdf_pkg::FLAG_OFS) ? wdata[FW-1:0] : '0;
    flag_next = (flag_reg & ~w1c) | ev; // set wins over clear
    irq_next  = |(flag_next & mask_next);
    task_next = |(ev & mask_reg);
    dma_next  = |rdy_ev;
    trip_next = cmp_ev;
    if (rd) begin
      case (addr)
        sdf_pkg::CTRL_OFS: rdata_next[sdf_pkg::CTRL_W-1:0] = ctrl_reg;
        sdf_pkg::DATA_OVERSAMPLING_RATIO_OFS: rdata_next[OW-1:0] = data_oversampling_ratio_reg;
        sdf_pkg::COMPARATOR_OVERSAMPLING_RATIO_OFS: rdata_next[OW-1:0] = comparator_oversampling_ratio_reg;
        sdf_pkg::LOW_OFS:  rdata_next[AC-1:0] = low_reg;
        sdf_pkg::HIGH_OFS: rdata_next[AC-1:0] = high_reg;
        sdf_pkg::FLAG_OFS: rdata_next[FW-1:0] = flag_reg;
        sdf_pkg::MASK_OFS: rdata_next[FW-1:0] = mask_reg;
        default: begin
          for (int i = 0; i < CH_N; i++) begin
            if (addr == sdf_pkg::DATA_BASE + 8'(4 * i)) begin
              rdata_next[AC-1:0] = ch_value[i];
            end
          end
        end
      endcase
    end
  end

  // register file and event outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg    <= sdf_pkg::CTRL_RST;
      data_oversampling_ratio_reg    <= sdf_pkg::DATA_OVERSAMPLING_RATIO_RST;
      comparator_oversampling_ratio_reg    <= sdf_pkg::COMPARATOR_OVERSAMPLING_RATIO_RST;
      low_reg     <= sdf_pkg::LOW_RST;
      high_reg    <= sdf_pkg::HIGH_RST;
      mask_reg    <= '0;
      flag_reg    <= '0;
      rdata_reg   <= '0;
      cmp_rst_reg <= 1'b0;
      dat_rst_reg <= 1'b0;
      irq_reg     <= 1'b0;
      task_reg    <= 1'b0;
      dma_reg     <= 1'b0;
      trip_reg    <= '0;
    end else begin
      ctrl_reg    <= ctrl_next;
      data_oversampling_ratio_reg    <= data_oversampling_ratio_next;
      comparator_oversampling_ratio_reg    <= comparator_oversampling_ratio_next;
      low_reg     <= low_next;
      high_reg    <= high_next;
      mask_reg    <= mask_next;
      flag_reg    <= flag_next;
      rdata_reg   <= rdata_next;
      cmp_rst_reg <= cmp_rst_next;
      dat_rst_reg <= dat_rst_next;
      irq_reg     <= irq_next;
      task_reg    <= task_next;
      dma_reg     <= dma_next;
      trip_reg    <= trip_next;
    end
  end

  assign rdata                 = rdata_reg;
  assign irq                   = irq_reg;
  assign math_coprocessor_task = task_reg;
  assign dma_trigger           = dma_reg;
  assign crossbar_trip         = trip_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ratio change restarts the comparator window
  comparator_oversampling_ratio_restart_a: assert property (
    (wr && addr == sdf_pkg::COMPARATOR_OVERSAMPLING_RATIO_OFS && wdata[OW-1:0] != comparator_oversampling_ratio_reg)
    |=> cmp_rst_reg)
    else $error("ratio change did not restart comparator");

  // forwarded comparator events reach crossbars and interrupt
  cmp_forward_a: assert property (
    (cmp_ie && |(ch_over | ch_under))
    |=> trip_reg == $past(ch_over | ch_under)
        && irq_reg == |(flag_reg & mask_reg))
    else $error("comparator event not forwarded");

  // forwarded data-ready reaches dma and flags
  dma_forward_a: assert property (
    (data_en && |ch_ready)
    |=> dma_reg
        && (flag_reg[FW-1:2*CH_N] & $past(ch_ready)) == $past(ch_ready))
    else $error("data-ready not forwarded");

  // over flags latch and hold against a same-cycle clear
  over_latch_a: assert property (
    (cmp_ie && |ch_over)
    |=> (flag_reg[CH_N-1:0] & $past(ch_over)) == $past(ch_over))
    else $error("over flag not latched");

  // comparator gate keeps new flags out
  cmp_gate_a: assert property (
    !cmp_ie |=> (flag_reg[2*CH_N-1:0] & ~$past(flag_reg[2*CH_N-1:0])) == '0)
    else $error("comparator flag set while disabled");

  // disabled data filter never triggers dma
  dma_gate_a: assert property (
    !data_en |=> !dma_reg)
    else $error("dma trigger while data filter disabled");

  // interrupt level tracks unmasked flags
  irq_level_a: assert property (
    irq_reg == |(flag_reg & mask_reg))
    else $error("interrupt level mismatch");

  // read data stand one cycle after the strobe only
  read_data_a: assert property (
    (rd && addr == sdf_pkg::FLAG_OFS)
    |=> rdata_reg[FW-1:0] == $past(flag_reg)
        ##1 ($past(rd) || rdata_reg == '0))
    else $error("flag read data wrong");

endmodule : sigma_delta_filter_module

// *** testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   mclk;
  logic [3:0]             bits;
  logic [sdf_pkg::AW-1:0] addr = '0;
  logic [sdf_pkg::DW-1:0] wdata = '0;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [sdf_pkg::DW-1:0] rdata;
  logic                   irq;
  logic                   task_pulse;
  logic                   dma_trigger;
  logic [3:0]             crossbar_trip;
  logic [31:0]            n_trip = '0;
  logic [31:0]            n_task = '0;
  logic [31:0]            n_dma = '0;
  logic [31:0]            d0;
  int                     n_mismatch = 0;
  int                     checks_done = 0;
  int                     cycles = 0;
  logic [7:0]             ofs_tab [8];
  logic [31:0]            rst_tab [8];
  logic [7:0]             chg_ofs [4];
  logic [31:0]            chg_val [4];

  modulator_model modulator_model_inst (
    .mclk (mclk),
    .bits (bits)
  );

  sigma_delta_filter_module sigma_delta_filter_module_inst (
    .clk                   (clk),
    .rst                   (rst),
    .modulator_clock_input (mclk),
    .bitstream             (bits),
    .addr                  (addr),
    .wdata                 (wdata),
    .wr                    (wr),
    .rd                    (rd),
    .rdata                 (rdata),
    .irq                   (irq),
    .math_coprocessor_task (task_pulse),
    .dma_trigger           (dma_trigger),
    .crossbar_trip         (crossbar_trip)
  );

  // 10 MHz system clock
  always #50 clk = ~clk;

  // count event pulses and cut a hang short
  always @(posedge clk) begin
    if (|crossbar_trip) n_trip <= n_trip + 32'h0000_0001;
    if (task_pulse) n_task <= n_task + 32'h0000_0001;
    if (dma_trigger) n_dma <= n_dma + 32'h0000_0001;
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] v;
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    check(v & m, e);
  endtask : rd_chk

  // main sequence
  initial begin
    ofs_tab = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    rst_tab = '{32'h0000_0000, 32'h0000_0020, 32'h0000_0010, 32'h0000_0010,
                32'h0000_00f0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    chg_ofs = '{sdf_pkg::COMPARATOR_OVERSAMPLING_RATIO_OFS, sdf_pkg::LOW_OFS, sdf_pkg::HIGH_OFS,
                sdf_pkg::CTRL_OFS};
    chg_val = '{32'h0000_00fd, 32'h0000_0011, 32'h0000_00f1, 32'h0000_000a};
    tick(10);
    rst <= 1'b0;
    // reset values, unmapped address reads zero
    for (int i = 0; i < 8; i++) begin
      rd_chk(ofs_tab[i], 32'hffff_ffff, rst_tab[i]);
    end
    // comparator change with its interrupt disabled forwards nothing
    wr_reg(sdf_pkg::COMPARATOR_OVERSAMPLING_RATIO_OFS, 32'h0000_00ff);
    // settle: pipeline plus five modulator clocks before enabling
    tick(48);
    rd_chk(sdf_pkg::FLAG_OFS, 32'hffff_ffff, 32'h0);
    check(n_trip | n_task, 32'h0);
    // enable comparator interrupt, unmask all, clear flags
    wr_reg(sdf_pkg::MASK_OFS, 32'h0000_0fff);
    wr_reg(sdf_pkg::CTRL_OFS, 32'hffff_fff2);
    rd_chk(sdf_pkg::CTRL_OFS, 32'hffff_ffff, 32'h0000_0002);
    wr_reg(sdf_pkg::FLAG_OFS, 32'h0000_0fff);
    tick(8);
    rd_chk(sdf_pkg::FLAG_OFS, 32'hffff_ffff, 32'h0);
    // each comparator setting change yields a ch1 under-value event
    for (int i = 0; i < 4; i++) begin
      wr_reg(sdf_pkg::FLAG_OFS, 32'h0000_0fff);
      wr_reg(chg_ofs[i], chg_val[i]);
      tick(8);
      rd_chk(sdf_pkg::FLAG_OFS, 32'h0000_0020, 32'h0000_0020);
      #1 check({31'h0, irq}, 32'h1);
    end
    check(32'(n_trip != 32'h0), 32'h1);
    check(32'(n_task != 32'h0), 32'h1);
    wr_reg(sdf_pkg::MASK_OFS, 32'h0);
    #1 check({31'h0, irq}, 32'h0);
    // data setting change while the filter is disabled forwards nothing
    wr_reg(sdf_pkg::CTRL_OFS, 32'h0);
    d0 = n_dma;
    wr_reg(sdf_pkg::DATA_OVERSAMPLING_RATIO_OFS, 32'h0000_00ff);
    tick(8);
    rd_chk(sdf_pkg::FLAG_OFS, 32'h0000_0f00, 32'h0);
    check(n_dma - d0, 32'h0);
    // ratio and type changes while enabled each give one data-ready event
    wr_reg(sdf_pkg::CTRL_OFS, 32'h0000_0001);
    tick(30);
    chg_ofs[0] = sdf_pkg::DATA_OVERSAMPLING_RATIO_OFS;
    chg_val[0] = 32'h0000_00fe;
    chg_ofs[1] = sdf_pkg::CTRL_OFS;
    chg_val[1] = 32'h0000_0005;
    for (int i = 0; i < 2; i++) begin
      wr_reg(sdf_pkg::FLAG_OFS, 32'h0000_0fff);
      d0 = n_dma;
      wr_reg(chg_ofs[i], chg_val[i]);
      tick(8);
      rd_chk(sdf_pkg::FLAG_OFS, 32'h0000_0f00, 32'h0000_0f00);
      check(n_dma - d0, 32'h1);
    end
    // disable, change, settle, re-enable: no spurious data-ready
    wr_reg(sdf_pkg::CTRL_OFS, 32'h0000_0004);
    wr_reg(sdf_pkg::DATA_OVERSAMPLING_RATIO_OFS, 32'h0000_0080);
    d0 = n_dma;
    tick(1100);
    wr_reg(sdf_pkg::CTRL_OFS, 32'h0000_0005);
    wr_reg(sdf_pkg::FLAG_OFS, 32'h0000_0fff);
    tick(20);
    check(n_dma - d0, 32'h0);
    rd_chk(sdf_pkg::FLAG_OFS, 32'h0000_0f00, 32'h0);
    // one full sinc2 window of 128 samples: ch0 ones, ch1 zeros
    tick(1100);
    check(n_dma - d0, 32'h1);
    rd_chk(sdf_pkg::FLAG_OFS, 32'h0000_0f00, 32'h0000_0f00);
    rd_chk(sdf_pkg::DATA_BASE, 32'hffff_ffff, 32'h0000_2040);
    rd_chk(sdf_pkg::DATA_BASE + 8'h04, 32'hffff_ffff, 32'h0);
    stop_test();
  end
endmodule : testbench
